// file: core/emap_pkg.sv
// constants, types and source layout for the error interrupt pin mapper
package emap_pkg;
    localparam int ADDR_W    = 12;
    localparam int DATA_W    = 32;
    localparam int SEL_W     = 3;
    localparam int N_SRC     = 19;
    localparam int N_PIN     = 8;
    localparam int N_MAP     = 4;
    localparam int SLOT_TOP  = 29;
    localparam int SLOT_STEP = 4;

    // map register index within the map array
    localparam int MAP_PCI2  = 0;
    localparam int MAP_PBERR = 1;
    localparam int MAP_RETRY = 2;
    localparam int MAP_MISC  = 3;

    localparam logic [ADDR_W-1:0] OFF_PCI2_ERROR_MAP    = 12'h434;
    localparam logic [ADDR_W-1:0] OFF_PROCBUS_ERROR_MAP = 12'h438;
    localparam logic [ADDR_W-1:0] OFF_PROCBUS_RETRY_MAP = 12'h43C;
    localparam logic [ADDR_W-1:0] OFF_MISC_INTR_MAP     = 12'h440;
    localparam logic [ADDR_W-1:0] OFF_EVENT_STATUS      = 12'h480;
    localparam logic [ADDR_W-1:0] OFF_EVENT_MASK        = 12'h484;

    localparam logic [DATA_W-1:0] MAP_RESET        = 32'h00000000;
    localparam logic [N_SRC-1:0]  EVT_RESET        = 19'h00000;
    // writable selector bits per map register, with single-pci variants for the pbus error and retry maps
    localparam logic [DATA_W-1:0] MASK_PCI2        = 32'hEEEEEEE0;
    localparam logic [DATA_W-1:0] MASK_PBERR       = 32'hEEEEEEE0;
    localparam logic [DATA_W-1:0] MASK_PBERR_1P    = 32'hE0EEE0E0;
    localparam logic [DATA_W-1:0] MASK_RETRY       = 32'hEEE00000;
    localparam logic [DATA_W-1:0] MASK_RETRY_1P    = 32'hE0E00000;
    localparam logic [DATA_W-1:0] MASK_MISC        = 32'hEE000000;

    typedef enum logic [SEL_W-1:0] {
        PIN_FIRST_PCI  = 3'h0,
        PIN_SECOND_PCI = 3'h1,
        PIN_GEN0       = 3'h2,
        PIN_GEN1       = 3'h3,
        PIN_GEN2       = 3'h4,
        PIN_GEN3       = 3'h5,
        PIN_GEN4       = 3'h6,
        PIN_GEN5       = 3'h7
    } emap_pin_type;

    // bit k of each vector is selector slot k of its register
    typedef struct packed {
        logic       msg_host;
        logic       msg_ioproc;
        logic [2:0] pbus_retry;
        logic [6:0] pbus_err;
        logic [6:0] pci2_err;
    } emap_src_type;

    function automatic int src_reg(input int i);
        return (i < 7) ? MAP_PCI2 : (i < 14) ? MAP_PBERR : (i < 17) ? MAP_RETRY : MAP_MISC;
    endfunction

    function automatic int src_lsb(input int i);
        int b;
        b = (i < 7) ? 0 : (i < 14) ? 7 : (i < 17) ? 14 : 17;
        return SLOT_TOP - SLOT_STEP * (i - b);
    endfunction
endpackage

// file: core/emap_router.sv
// per-pin decode of source selectors, or-combining shared pins
`timescale 1ns/100ps
module emap_router #(
    parameter int N_SRC = 19,
    parameter int N_PIN = 8,
    parameter int SEL_W = 3
) (
    // sources and their selectors
    input  wire logic [N_SRC-1:0]       src_act,
    input  wire logic [N_SRC*SEL_W-1:0] sel_flat,
    // pin requests
    output logic      [N_PIN-1:0]       pin_hit
);
    logic [N_SRC-1:0] match [N_PIN];

    for (genvar p = 0; p < N_PIN; p++) begin : g_pin
        for (genvar s = 0; s < N_SRC; s++) begin : g_src
            assign match[p][s] = sel_flat[s*SEL_W +: SEL_W] == SEL_W'(p);
        end
        assign pin_hit[p] = |(src_act & match[p]);
    end
endmodule // emap_router

// file: core/emap_events.sv
// sticky event status, mask and interrupt level
`timescale 1ns/100ps
module emap_events #(
    parameter int N_SRC = 19
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    // event sources
    input  wire logic [N_SRC-1:0] src_act,
    // software access
    input  wire logic             wr_stat,
    input  wire logic             wr_mask,
    input  wire logic [N_SRC-1:0] wdata,
    // state
    output logic      [N_SRC-1:0] stat_q,
    output logic      [N_SRC-1:0] mask_q,
    output logic                  irq
);
    logic [N_SRC-1:0] prev_q;
    logic [N_SRC-1:0] rise;
    logic [N_SRC-1:0] clr;
    logic [N_SRC-1:0] stat_d;

    assign rise   = src_act & ~prev_q;
    assign clr    = wr_stat ? wdata : '0;
    // a new event wins over a clear in the same cycle
    assign stat_d = (stat_q & ~clr) | rise;
    assign irq    = |(stat_q & mask_q);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prev_q <= emap_pkg::EVT_RESET;
            stat_q <= emap_pkg::EVT_RESET;
            mask_q <= emap_pkg::EVT_RESET;
        end else begin
            prev_q <= src_act;
            stat_q <= stat_d;
            if (wr_mask) begin
                mask_q <= wdata;
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sticky_set_a: assert property (|rise |=> (stat_q & $past(rise)) == $past(rise))
        else $error("event rise not held in status");
    irq_level_a: assert property (|(rise & mask_q) && !wr_mask |=> irq)
        else $error("interrupt level disagrees with status and mask");
endmodule // emap_events

// file: core/emap_top.sv
// error and message interrupt pin mapper with apb register port
`timescale 1ns/100ps
module emap_top #(
    parameter bit DUAL_PCI = 1'b1
) (
    // clock and reset
    input  wire logic                          clk_sys,
    input  wire logic                          rst_n,
    // apb slave
    input  wire logic [emap_pkg::ADDR_W-1:0]   paddr,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [emap_pkg::DATA_W-1:0]   pwdata,
    input  wire logic [3:0]                    pstrb,
    output logic                               pready,
    output logic      [emap_pkg::DATA_W-1:0]   prdata,
    output logic                               pslverr,
    // interrupt sources
    input  wire emap_pkg::emap_src_type        src_in,
    // interrupt pin requests, active high
    output logic                               first_pci_irq_pin,
    output logic                               second_pci_irq_pin,
    output logic      [5:0]                    gen_irq_pin,
    // event interrupt
    output logic                               irq
);
    localparam int NS = emap_pkg::N_SRC;
    localparam int SW = emap_pkg::SEL_W;

    // writable bits per map register for this build
    localparam logic [31:0] FMASK [emap_pkg::N_MAP] = '{
        DUAL_PCI ? emap_pkg::MASK_PCI2  : 32'h00000000,
        DUAL_PCI ? emap_pkg::MASK_PBERR : emap_pkg::MASK_PBERR_1P,
        DUAL_PCI ? emap_pkg::MASK_RETRY : emap_pkg::MASK_RETRY_1P,
        emap_pkg::MASK_MISC
    };
    localparam logic [11:0] MOFF [emap_pkg::N_MAP] = '{
        emap_pkg::OFF_PCI2_ERROR_MAP,
        emap_pkg::OFF_PROCBUS_ERROR_MAP,
        emap_pkg::OFF_PROCBUS_RETRY_MAP,
        emap_pkg::OFF_MISC_INTR_MAP
    };

    logic [31:0]           map_q   [emap_pkg::N_MAP];
    logic [emap_pkg::N_MAP-1:0] hit_map;
    logic                  hit_stat;
    logic                  hit_mask;
    logic                  mapped;
    logic                  setup;
    logic                  access;
    logic                  wr;
    logic [31:0]           bmask;
    logic [31:0]           rd_map;
    logic [31:0]           rd_data;
    logic [31:0]           prdata_q;
    logic                  err_q;
    logic [NS-1:0]         src_vec;
    logic [NS-1:0]         src_valid;
    logic [NS-1:0]         src_act;
    logic [NS*SW-1:0]      sel_flat;
    logic [emap_pkg::N_PIN-1:0] pin_hit;
    logic [emap_pkg::N_PIN-1:0] pin_q;
    logic [NS-1:0]         stat_q;
    logic [NS-1:0]         mask_q;

    // apb phase and address decode
    assign setup    = psel & ~penable;
    assign access   = psel & penable;
    assign wr       = access & pwrite;
    assign hit_stat = paddr == emap_pkg::OFF_EVENT_STATUS;
    assign hit_mask = paddr == emap_pkg::OFF_EVENT_MASK;
    assign mapped   = (|hit_map) | hit_stat | hit_mask;
    assign bmask    = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    // map registers: each selector is its own masked nibble field
    for (genvar j = 0; j < emap_pkg::N_MAP; j++) begin : g_map
        logic [31:0] wm;
        assign hit_map[j] = paddr == MOFF[j];
        assign wm         = FMASK[j] & bmask;
        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                map_q[j] <= emap_pkg::MAP_RESET;
            end else if (wr && hit_map[j]) begin
                map_q[j] <= (map_q[j] & ~wm) | (pwdata & wm);
            end
        end
    end

    assign rd_map = ({32{hit_map[0]}} & map_q[0])
                  | ({32{hit_map[1]}} & map_q[1])
                  | ({32{hit_map[2]}} & map_q[2])
                  | ({32{hit_map[3]}} & map_q[3]);
    assign rd_data = rd_map
                   | ({32{hit_stat}} & {13'h0000, stat_q})
                   | ({32{hit_mask}} & {13'h0000, mask_q});

    // read data and error are captured in setup, so access needs no wait
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prdata_q <= 32'h00000000;
            err_q    <= 1'b0;
        end else if (setup) begin
            prdata_q <= pwrite ? 32'h00000000 : rd_data;
            err_q    <= ~mapped;
        end
    end

    assign pready  = 1'b1;
    assign prdata  = prdata_q;
    assign pslverr = access & err_q;

    // selector extraction: slot k of a register sits at bits lsb+2..lsb
    assign src_vec = src_in;
    for (genvar i = 0; i < NS; i++) begin : g_sel
        localparam int RG = emap_pkg::src_reg(i);
        localparam int LB = emap_pkg::src_lsb(i);
        assign sel_flat[i*SW +: SW] = map_q[RG][LB +: SW];
        // absent fields in the single-pci build never drive a pin
        assign src_valid[i] = FMASK[RG][LB];
    end
    assign src_act = src_vec & src_valid;

    emap_router #(
        .N_SRC (NS),
        .N_PIN (emap_pkg::N_PIN),
        .SEL_W (SW)
    ) u_router (
        .src_act  (src_act),
        .sel_flat (sel_flat),
        .pin_hit  (pin_hit)
    );

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_q <= 8'h00;
        end else begin
            pin_q <= pin_hit;
        end
    end

    assign first_pci_irq_pin  = pin_q[emap_pkg::PIN_FIRST_PCI];
    assign second_pci_irq_pin = pin_q[emap_pkg::PIN_SECOND_PCI];
    assign gen_irq_pin        = pin_q[emap_pkg::PIN_GEN5:emap_pkg::PIN_GEN0];

    emap_events #(
        .N_SRC (NS)
    ) u_events (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .src_act (src_act),
        .wr_stat (wr & hit_stat),
        .wr_mask (wr & hit_mask),
        .wdata   (pwdata[NS-1:0]),
        .stat_q  (stat_q),
        .mask_q  (mask_q),
        .irq     (irq)
    );

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // every source reaches exactly the pin its selector names
    for (genvar i = 0; i < NS; i++) begin : g_chk
        src_route_a: assert property (
            src_act[i] |=> pin_q[$past(sel_flat[i*SW +: SW])])
            else $error("active source missing on its selected pin");
    end

    pin_idle_a: assert property (
        !(|src_act) |=> pin_q == 8'h00)
        else $error("pin asserted with no active source");

    apar_pin_a: assert property (
        src_act[10] && map_q[1][19:17] == 3'h0 |=> first_pci_irq_pin)
        else $error("address parity error not on first pci pin");

    dpar_split_a: assert property (
        wr && hit_map[1] && pstrb == 4'hF
        |=> map_q[1][15:13] == $past(pwdata[15:13])
            && map_q[1][11:9] == ($past(pwdata[11:9]) & FMASK[1][11:9])
            && map_q[1][7:5] == $past(pwdata[7:5]))
        else $error("data parity selectors not written independently");

    retry_rsvd_a: assert property (
        (map_q[2] & ~FMASK[2]) == 32'h00000000
        && (map_q[0] & ~FMASK[0]) == 32'h00000000
        && (map_q[1] & ~FMASK[1]) == 32'h00000000)
        else $error("reserved map bits not zero");

    misc_only_a: assert property (
        wr && hit_map[3] |=> (map_q[3] & 32'h11FFFFFF) == 32'h00000000)
        else $error("misc map holds bits beyond its two selectors");

    pci2_dma_a: assert property (
        src_act[2] && src_act[6] && sel_flat[8:6] != sel_flat[20:18]
        |=> pin_q[$past(sel_flat[8:6])] && pin_q[$past(sel_flat[20:18])])
        else $error("second pci dma selectors not independent");

    single_pci_a: assert property (
        !DUAL_PCI |-> map_q[0] == 32'h00000000
                      && map_q[1][27:25] == 3'h0 && map_q[2][27:25] == 3'h0)
        else $error("single pci build holds a reserved selector");

    map_read_a: assert property (
        setup && !pwrite && hit_map[2] ##1 access |-> prdata == map_q[2])
        else $error("map register read mismatch");

    map_write_a: assert property (
        wr && hit_map[3] && pstrb == 4'hF
        |=> map_q[3] == ($past(pwdata) & emap_pkg::MASK_MISC))
        else $error("map register write not stored");

    bad_addr_a: assert property (
        setup && !mapped ##1 access |-> pslverr)
        else $error("unmapped address not flagged");
endmodule // emap_top

// file: dv/emap_src_model.sv
// source driver standing in for the bridge cores that raise error and message events
`timescale 1ns/100ps
module emap_src_model (
    // clock
    input  wire logic              clk_sys,
    // requested source levels
    input  wire logic [18:0]       want,
    // sources toward the mapper
    output emap_pkg::emap_src_type src_in
);
    // sources change just after an edge, as the bridge cores would
    always_ff @(posedge clk_sys) begin
        src_in <= want;
    end
endmodule // emap_src_model

// file: dv/error_interrupt_pin_mapper_tb.sv
// self-checking bench for the error interrupt pin mapper, both builds
`timescale 1ns/100ps
module error_interrupt_pin_mapper_tb;
    logic                   clk_sys;
    logic                   rst_n;
    logic [11:0]            paddr;
    logic                   psel;
    logic                   penable;
    logic                   pwrite;
    logic [31:0]            pwdata;
    logic [3:0]             strb;
    logic                   tgt;
    logic [18:0]            want;
    logic [31:0]            rd0;
    logic [31:0]            rd1;
    logic                   rdy0;
    logic                   rdy1;
    logic                   err0;
    logic                   err1;
    logic                   irq0;
    logic                   p1;
    logic                   p2;
    logic [5:0]             g;
    logic [7:0]             pins;
    logic                   q1;
    logic                   q2;
    logic [5:0]             qg;
    logic [7:0]             pins1;
    logic [31:0]            rdata;
    logic                   rerr;
    emap_pkg::emap_src_type src;
    int                     failures;
    int                     checks_done;
    logic [31:0]            rb_dual [4] = '{32'hEEEEEEE0, 32'hEEEEEEE0, 32'hEEE00000, 32'hEE000000};
    logic [31:0]            rb_one  [4] = '{32'h00000000, 32'hE0EEE0E0, 32'hE0E00000, 32'hEE000000};

    assign pins  = {g, p2, p1};
    assign pins1 = {qg, q2, q1};

    emap_src_model SRC (.clk_sys(clk_sys), .want(want), .src_in(src));

    emap_top #(.DUAL_PCI(1'b1)) DUT (
        .clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr), .psel(psel & ~tgt),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(strb),
        .pready(rdy0), .prdata(rd0), .pslverr(err0), .src_in(src),
        .first_pci_irq_pin(p1), .second_pci_irq_pin(p2), .gen_irq_pin(g), .irq(irq0));

    emap_top #(.DUAL_PCI(1'b0)) DUT1 (
        .clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr), .psel(psel & tgt),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(strb),
        .pready(rdy1), .prdata(rd1), .pslverr(err1), .src_in(src),
        .first_pci_irq_pin(q1), .second_pci_irq_pin(q2), .gen_irq_pin(qg), .irq());

    task automatic end_of_test();
        if (failures == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t %s: got %b expected %b", $time, what, got, exp);
        end
    endtask

    // one apb transfer; holds the request until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic t);
        int n;
        @(posedge clk_sys);
        tgt     <= t;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while ((t ? rdy1 : rdy0) !== 1'b1 && n < 16);
        if (n >= 16) begin
            failures++;
            $display("ERROR %0t no pready", $time);
            end_of_test();
        end
        rdata = t ? rd1 : rd0;
        rerr  = t ? err1 : err0;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic t);
        apb(1'b0, a, 32'h00000000, t);
        chk_word(rdata, e, "register read");
    endtask

    // drive sources, let the pin register settle, compare the pin vector
    task automatic src_pins(input logic [18:0] s, input logic [7:0] e);
        @(posedge clk_sys);
        want <= s;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        chk_word({24'h000000, pins}, {24'h000000, e}, "pin vector");
        chk_word({24'h000000, pins1}, {31'h00000000, |(s & 19'h76E80)}, "1p pins");
    endtask

    function automatic logic [11:0] src_off(input int i);
        return (i < 7) ? 12'h434 : (i < 14) ? 12'h438 : (i < 17) ? 12'h43C : 12'h440;
    endfunction

    function automatic int src_shift(input int i);
        int k;
        k = (i < 7) ? i : (i < 14) ? i - 7 : (i < 17) ? i - 14 : i - 17;
        return 29 - 4 * k;
    endfunction

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
        pwdata = 32'h00000000; strb = 4'hF; tgt = 1'b0; want = 19'h00000;
        failures = 0; checks_done = 0;
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int r = 0; r < 4; r++) begin
            rd_chk(12'h434 + 12'(4 * r), 32'h00000000, 1'b0);
            apb(1'b1, 12'h434 + 12'(4 * r), 32'hFFFFFFFF, 1'b0);
            apb(1'b1, 12'h434 + 12'(4 * r), 32'hFFFFFFFF, 1'b1);
            rd_chk(12'h434 + 12'(4 * r), rb_dual[r], 1'b0);
            rd_chk(12'h434 + 12'(4 * r), rb_one[r], 1'b1);
        end
        apb(1'b1, 12'h400, 32'hFFFFFFFF, 1'b0);
        chk_bit(rerr, 1'b1, "unmapped write error");
        rd_chk(12'h400, 32'h00000000, 1'b0);
        chk_bit(rerr, 1'b1, "unmapped read error");
        strb <= 4'h7;
        apb(1'b1, 12'h440, 32'h00000000, 1'b0);
        strb <= 4'hF;
        rd_chk(12'h440, 32'hEE000000, 1'b0);
        rst_n <= 1'b0;
        @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int r = 0; r < 4; r++) rd_chk(12'h434 + 12'(4 * r), 32'h00000000, 1'b0);
        for (int i = 0; i < 19; i++) begin
            for (int v = 0; v < 8; v++) begin
                apb(1'b1, src_off(i), 32'(v) << src_shift(i), 1'b0);
                src_pins(19'(1) << i, 8'(1) << v);
                src_pins(19'h00000, 8'h00);
            end
            apb(1'b1, src_off(i), 32'h00000000, 1'b0);
        end
        apb(1'b1, 12'h438, (32'h4 << 17) | (32'h4 << 5), 1'b0);
        src_pins(19'h02400, 8'h10);
        src_pins(19'h02000, 8'h10);
        src_pins(19'h00000, 8'h00);
        apb(1'b1, 12'h440, 32'h3 << 29, 1'b0);
        src_pins(19'h40000, 8'h01);
        src_pins(19'h20000, 8'h08);
        src_pins(19'h00000, 8'h00);
        apb(1'b1, 12'h434, (32'h5 << 21) | (32'h6 << 5), 1'b0);
        src_pins(19'h00044, 8'h60);
        src_pins(19'h00000, 8'h00);
        rd_chk(12'h480, 32'h0007FFFF, 1'b0);
        chk_bit(irq0, 1'b0, "irq masked");
        apb(1'b1, 12'h484, 32'h00000400, 1'b0);
        @(negedge clk_sys);
        chk_bit(irq0, 1'b1, "irq enabled");
        apb(1'b1, 12'h480, 32'h00000400, 1'b0);
        @(negedge clk_sys);
        chk_bit(irq0, 1'b0, "irq cleared");
        rd_chk(12'h480, 32'h0007FBFF, 1'b0);
        src_pins(19'h00400, 8'h10);
        chk_bit(irq0, 1'b1, "irq on new event");
        apb(1'b1, 12'h484, 32'h00000000, 1'b0);
        @(negedge clk_sys);
        chk_bit(irq0, 1'b0, "irq masked again");
        end_of_test();
    end
endmodule // error_interrupt_pin_mapper_tb
